// [src/cdp_pkg.sv]
// shared constants and types of the configuration loader front end
package cdp_pkg;
    // ==========================================================
    // timing
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned FAST_POR_NS   = 3000;
    localparam int unsigned STD_POR_NS    = 100000;
    localparam int unsigned FAST_POR_CYC  =
        (FAST_POR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STD_POR_CYC   =
        (STD_POR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned IN_GAP_CYC    = 8;
    // ==========================================================
    // mode-select pin fields
    localparam int MODE_W          = 3;
    localparam int MODE_SCHEME_LSB = 0;
    localparam int MODE_FAST_BIT   = 2;
    typedef enum logic [1:0] {
        SCH_SERIAL_MEM  = 2'h0,
        SCH_PAR_FLASH   = 2'h1,
        SCH_HOST_SERIAL = 2'h2,
        SCH_HOST_PAR    = 2'h3
    } cdp_scheme_t;
    // ==========================================================
    // stream format
    localparam int         DATA_W       = 8;
    localparam int         CNT_W        = 16;
    localparam int         HDR_IDX_W    = 2;
    localparam int         HDR_COMP_BIT = 0;
    localparam logic [1:0] HDR_FLAGS    = 2'h0;
    localparam logic [1:0] HDR_CNT_HI   = 2'h1;
    localparam logic [1:0] HDR_CNT_LO   = 2'h2;
    localparam logic [7:0] ESC_CODE     = 8'h00;
    localparam logic [7:0] FILL_CODE    = 8'h00;
    localparam int         RUN_W        = 2;
    localparam logic [15:0] ADDR_RST    = 16'h0000;
    // ==========================================================
    // states
    typedef enum logic [5:0] {
        ST_POR  = 6'h01,
        ST_HOLD = 6'h02,
        ST_HDR  = 6'h04,
        ST_LOAD = 6'h08,
        ST_DONE = 6'h10,
        ST_ERR  = 6'h20
    } cdp_state_t;
    typedef enum logic [2:0] {
        DC_IDLE = 3'h1,
        DC_CNT  = 3'h2,
        DC_RUN  = 3'h4
    } cdp_dstate_t;
endpackage

// [src/cdp_decomp.sv]
// real-time run-length expander between stream input and cell writer
`timescale 1ns/100ps
module cdp_decomp #(
    parameter int DW = cdp_pkg::DATA_W,
    parameter int RW = cdp_pkg::RUN_W
) (
    input  wire logic          clk_i,
    input  wire logic          resetn_i,
    input  wire logic          ce_i,
    input  wire logic          clear_i,
    input  wire logic          comp_en_i,
    input  wire logic          in_valid_i,
    input  wire logic [DW-1:0] in_data_i,
    output logic               out_valid_o,
    output logic      [DW-1:0] out_data_o
);
    import cdp_pkg::*;

    typedef struct packed {
        cdp_dstate_t   st;
        logic [RW-1:0] run;
        logic          ov;
        logic [DW-1:0] od;
    } cdp_dec_t;

    cdp_dec_t q;
    cdp_dec_t next_q;

    // ==========================================================
    // expander: escape, count n, then n+1 fill words
    always_comb begin
        next_q    = q;
        next_q.ov = 1'b0;
        if (clear_i) begin
            next_q.st  = DC_IDLE;
            next_q.run = '0;
        end else begin
            unique case (q.st)
                DC_IDLE: begin
                    if (in_valid_i) begin
                        if (comp_en_i && in_data_i == ESC_CODE) begin
                            next_q.st = DC_CNT;
                        end else begin
                            next_q.ov = 1'b1;
                            next_q.od = in_data_i;
                        end
                    end
                end
                DC_CNT: begin
                    if (in_valid_i) begin
                        next_q.ov  = 1'b1;
                        next_q.od  = FILL_CODE;
                        next_q.run = in_data_i[RW-1:0];
                        if (in_data_i[RW-1:0] != '0) begin
                            next_q.st = DC_RUN;
                        end else begin
                            next_q.st = DC_IDLE;
                        end
                    end
                end
                DC_RUN: begin
                    // one word a cycle, so a run ends before the next byte
                    next_q.ov  = 1'b1;
                    next_q.od  = FILL_CODE;
                    next_q.run = q.run - 1'b1;
                    if (q.run == 1) begin
                        next_q.st = DC_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q    <= '0;
            q.st <= DC_IDLE;
        end else if (ce_i) begin
            q <= next_q;
        end
    end

    assign out_valid_o = q.ov;
    assign out_data_o  = q.od;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i || !ce_i);

    sequence s_run_start;
        q.st == DC_CNT && in_valid_i && !clear_i && in_data_i[RW-1:0] != 0;
    endsequence
    sequence s_fill;
        out_valid_o && out_data_o == FILL_CODE;
    endsequence

    pass_through_a: assert property (
        q.st == DC_IDLE && in_valid_i && !comp_en_i && !clear_i
        |=> out_valid_o && out_data_o == $past(in_data_i))
        else $error("raw byte not passed through");
    // a load that ends inside a run clears the expander early
    run_fill_a: assert property (
        s_run_start |=> s_fill ##1
        ($past(clear_i) || out_valid_o && out_data_o == FILL_CODE))
        else $error("run did not emit fill words");
    run_bound_a: assert property (
        s_run_start |=> ##[1:4] q.st == DC_IDLE)
        else $error("run outlasted input spacing");
endmodule

// [src/cdp_loader.sv]
// configuration loader front end: power-on reset, restart, stream load
`timescale 1ns/100ps
module cdp_loader #(
    parameter int POR_W     = 16,
    parameter int FAST_CYC  = cdp_pkg::FAST_POR_CYC,
    parameter int STD_CYC   = cdp_pkg::STD_POR_CYC
) (
    input  wire logic                          CLK_I,
    input  wire logic                          RESETN_I,
    input  wire logic                          CE_I,
    input  wire logic                          CORE_SUPPLY_GOOD_I,
    input  wire logic                          ANALOG_SUPPLY_GOOD_I,
    input  wire logic                          IO_SUPPLY_GOOD_I,
    input  wire logic [cdp_pkg::MODE_W-1:0]    MODE_SELECT_PINS_I,
    input  wire logic                          REMOTE_OPTION_I,
    input  wire logic                          TEST_PORT_CFG_I,
    input  wire logic                          RESTART_INPUT_N_I,
    input  wire logic                          CFG_VALID_I,
    input  wire logic [cdp_pkg::DATA_W-1:0]    CFG_DATA_I,
    output logic                               STATUS_OPEN_DRAIN_N_O,
    output logic                               STATUS_OPEN_DRAIN_N_OE_O,
    output logic                               LOAD_COMPLETE_O,
    output logic                               LOAD_COMPLETE_OE_O,
    output logic                               DEVICE_IN_RESET_O,
    output logic                               REMOTE_UPDATE_O,
    output logic                               CELL_WE_O,
    output logic [cdp_pkg::CNT_W-1:0]          CELL_ADDR_O,
    output logic [cdp_pkg::DATA_W-1:0]         CELL_DATA_O
);
    import cdp_pkg::*;

    typedef struct packed {
        cdp_state_t           st;
        logic [POR_W-1:0]     por_cnt;
        logic                 fast;
        logic [HDR_IDX_W-1:0] hdr_idx;
        logic                 comp;
        logic [CNT_W-1:0]     left;
        logic [CNT_W-1:0]     addr;
        logic [CNT_W-1:0]     waddr;
        logic                 we;
        logic [DATA_W-1:0]    wdata;
        logic                 status_oe;
        logic                 done_oe;
        logic                 in_reset;
        logic                 remote;
    } cdp_top_t;

    localparam logic [POR_W-1:0] FAST_LIM = POR_W'(FAST_CYC - 1);
    localparam logic [POR_W-1:0] STD_LIM  = POR_W'(STD_CYC - 1);

    cdp_top_t          q;
    cdp_top_t          next_q;
    logic              dec_valid;
    logic [DATA_W-1:0] dec_data;
    cdp_scheme_t       scheme;
    logic              serial_sch;
    logic              master_sch;
    logic              all_good;
    logic              brown_out;

    // ==========================================================
    // pin decode
    assign scheme     = cdp_scheme_t'(
                            MODE_SELECT_PINS_I[MODE_SCHEME_LSB +: 2]);
    assign serial_sch = scheme == SCH_SERIAL_MEM || scheme == SCH_HOST_SERIAL;
    assign master_sch = scheme == SCH_SERIAL_MEM || scheme == SCH_PAR_FLASH;
    assign all_good   = CORE_SUPPLY_GOOD_I && ANALOG_SUPPLY_GOOD_I &&
                        IO_SUPPLY_GOOD_I;
    assign brown_out  = !CORE_SUPPLY_GOOD_I || !ANALOG_SUPPLY_GOOD_I;

    // ==========================================================
    // expander; cleared outside the load state
    cdp_decomp #(
        .DW (DATA_W),
        .RW (RUN_W)
    ) u_decomp (
        .clk_i       (CLK_I),
        .resetn_i    (RESETN_I),
        .ce_i        (CE_I),
        .clear_i     (q.st != ST_LOAD),
        .comp_en_i   (q.comp),
        .in_valid_i  (q.st == ST_LOAD && CFG_VALID_I),
        .in_data_i   (CFG_DATA_I),
        .out_valid_o (dec_valid),
        .out_data_o  (dec_data)
    );

    // ==========================================================
    // sequencer
    always_comb begin
        next_q    = q;
        next_q.we = 1'b0;
        unique case (q.st)
            ST_POR: begin
                next_q.fast = MODE_SELECT_PINS_I[MODE_FAST_BIT];
                if (!all_good) begin
                    next_q.por_cnt = '0;
                end else if (q.por_cnt == (q.fast ? FAST_LIM : STD_LIM)) begin
                    next_q.st = ST_HOLD;
                end else begin
                    next_q.por_cnt = q.por_cnt + 1'b1;
                end
            end
            ST_HOLD: begin
                // host keeps restart low while slow supplies settle
                if (RESTART_INPUT_N_I) begin
                    next_q.st = ST_HDR;
                end
            end
            ST_HDR: begin
                if (CFG_VALID_I) begin
                    next_q.hdr_idx = q.hdr_idx + 1'b1;
                    unique case (q.hdr_idx)
                        HDR_FLAGS: begin
                            next_q.comp = CFG_DATA_I[HDR_COMP_BIT];
                            // parallel schemes carry no expander path
                            if (CFG_DATA_I[HDR_COMP_BIT] && !serial_sch) begin
                                next_q.st = ST_ERR;
                            end
                        end
                        HDR_CNT_HI: begin
                            next_q.left[CNT_W-1:DATA_W] = CFG_DATA_I;
                        end
                        HDR_CNT_LO: begin
                            next_q.left[DATA_W-1:0] = CFG_DATA_I;
                            if (q.left[CNT_W-1:DATA_W] == '0 &&
                                CFG_DATA_I == '0) begin
                                next_q.st = ST_DONE;
                            end else begin
                                next_q.st = ST_LOAD;
                            end
                        end
                        default: begin
                            next_q.st = ST_ERR;
                        end
                    endcase
                end
            end
            ST_LOAD: begin
                if (dec_valid) begin
                    next_q.we    = 1'b1;
                    next_q.wdata = dec_data;
                    next_q.waddr = q.addr;
                    next_q.addr  = q.addr + 1'b1;
                    next_q.left  = q.left - 1'b1;
                    if (q.left == 1) begin
                        next_q.st = ST_DONE;
                    end
                end
            end
            ST_DONE, ST_ERR: begin
            end
        endcase
        // restart and brown-out override every later state
        if (q.st != ST_POR) begin
            if (brown_out) begin
                next_q.st      = ST_POR;
                next_q.por_cnt = '0;
            end else if (!RESTART_INPUT_N_I) begin
                next_q.st = ST_HOLD;
            end
        end
        if (next_q.st == ST_POR || next_q.st == ST_HOLD) begin
            next_q.hdr_idx = '0;
            next_q.comp    = 1'b0;
            next_q.left    = '0;
            next_q.addr    = ADDR_RST;
            next_q.we      = 1'b0;
        end
        next_q.in_reset  = next_q.st == ST_POR || next_q.st == ST_HOLD;
        next_q.status_oe = next_q.in_reset || next_q.st == ST_ERR;
        next_q.done_oe   = next_q.st != ST_DONE;
        next_q.remote    = REMOTE_OPTION_I && master_sch &&
                           !TEST_PORT_CFG_I;
    end

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            q           <= '0;
            q.st        <= ST_POR;
            q.addr      <= ADDR_RST;
            q.status_oe <= 1'b1;
            q.done_oe   <= 1'b1;
            q.in_reset  <= 1'b1;
        end else if (CE_I) begin
            q <= next_q;
        end
    end

    // ==========================================================
    // outputs; open-drain levels stay low, only the enables move
    assign STATUS_OPEN_DRAIN_N_O    = 1'b0;
    assign LOAD_COMPLETE_O          = 1'b0;
    assign STATUS_OPEN_DRAIN_N_OE_O = q.status_oe;
    assign LOAD_COMPLETE_OE_O       = q.done_oe;
    assign DEVICE_IN_RESET_O        = q.in_reset;
    assign REMOTE_UPDATE_O          = q.remote;
    assign CELL_WE_O                = q.we;
    assign CELL_ADDR_O              = q.waddr;
    assign CELL_DATA_O              = q.wdata;

    // ==========================================================
    // checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESETN_I || !CE_I);

    sequence s_hold_release;
        q.st == ST_HOLD && RESTART_INPUT_N_I && !brown_out;
    endsequence
    sequence s_last_word;
        q.st == ST_LOAD && dec_valid && q.left == 1 && !brown_out &&
        RESTART_INPUT_N_I;
    endsequence

    por_hold_a: assert property (
        q.st == ST_POR && !all_good |=> q.st == ST_POR &&
        q.por_cnt == 0 && STATUS_OPEN_DRAIN_N_OE_O)
        else $error("reset released with supply low");
    brown_out_a: assert property (
        q.st != ST_POR && brown_out |=> q.st == ST_POR && DEVICE_IN_RESET_O)
        else $error("brown-out did not reset");
    por_delay_a: assert property (
        q.st == ST_POR ##1 q.st == ST_HOLD |->
        $past(q.por_cnt) == ($past(q.fast) ? FAST_LIM : STD_LIM))
        else $error("power-on delay wrong length");
    restart_hold_a: assert property (
        q.st != ST_POR && !RESTART_INPUT_N_I |=>
        q.st != ST_HDR && q.st != ST_LOAD && STATUS_OPEN_DRAIN_N_OE_O)
        else $error("restart low did not reset");
    restart_go_a: assert property (
        s_hold_release |=> q.st == ST_HDR && !STATUS_OPEN_DRAIN_N_OE_O &&
        !DEVICE_IN_RESET_O)
        else $error("restart release did not start load");
    done_release_a: assert property (
        s_last_word |=> CELL_WE_O && !LOAD_COMPLETE_OE_O)
        else $error("load-complete not released");
    remote_avail_a: assert property (
        REMOTE_UPDATE_O |-> $past(master_sch) && !$past(TEST_PORT_CFG_I))
        else $error("remote update in wrong scheme");
    hdr_route_a: assert property (
        q.st == ST_HDR && q.hdr_idx == HDR_FLAGS && CFG_VALID_I &&
        RESTART_INPUT_N_I && !brown_out |=>
        q.comp == $past(CFG_DATA_I[HDR_COMP_BIT]))
        else $error("header flag not taken");
    cell_write_a: assert property (
        q.st == ST_LOAD && dec_valid && RESTART_INPUT_N_I && !brown_out
        |=> CELL_WE_O && CELL_DATA_O == $past(dec_data) &&
        CELL_ADDR_O == $past(q.addr))
        else $error("expanded word not written");
endmodule

// [sim/cdp_cfg_src.sv]
// host-side model: restart pin and paced configuration byte source
`timescale 1ns/100ps
module cdp_cfg_src (
    input  wire logic                       clk_i,
    output logic                            restart_n_o,
    output logic                            valid_o,
    output logic [cdp_pkg::DATA_W-1:0]      data_o
);
    import cdp_pkg::*;
    // ==========================================================
    // power-up levels
    initial begin
        restart_n_o = 1'b0;
        valid_o     = 1'b0;
        data_o      = 8'h5a;
    end
    // ==========================================================
    // restart pin; host keeps it low while supplies settle
    task automatic set_restart(input logic v);
        @(posedge clk_i);
        restart_n_o <= v;
    endtask
    // ==========================================================
    // one byte per slot, sent as stored, never expanded
    task automatic send(input logic [DATA_W-1:0] b);
        @(posedge clk_i);
        valid_o <= 1'b1;
        data_o  <= b;
        @(posedge clk_i);
        valid_o <= 1'b0;
        // released line shows the inverse, so a stale byte cannot match
        data_o  <= ~b;
        repeat (IN_GAP_CYC - 2) @(posedge clk_i);
    endtask
endmodule

// [sim/tb.sv]
// self-checking bench of the configuration loader front end
`timescale 1ns/100ps
`define CHK(nm, exp, got) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) begin \
            fails++; \
            $display("MISMATCH %s expected %h seen %h", nm, exp, got); \
        end \
    end
module tb;
    import cdp_pkg::*;
    // ==========================================================
    // signals
    localparam int FAST = 5;
    localparam int STD  = 20;
    logic        clk = 1'b0;
    logic        resetn, ce, core_ok, ana_ok, io_ok, remote_opt, test_port;
    logic [2:0]  mode;
    wire         restart_n, cfg_valid;
    wire  [7:0]  cfg_data;
    logic        st_od, st_oe, done_od, done_oe, in_rst, remote, we;
    logic [15:0] addr;
    logic [7:0]  wdata;
    int          fails = 0;
    int          comparisons = 0;
    int          cyc = 0;
    logic [15:0] wa[$];
    logic [7:0]  wd[$];
    int          wt[$];
    always #2.5 clk = ~clk;
    // cell writes are one-cycle pulses, so they are logged at every edge
    always @(posedge clk) begin
        cyc++;
        if (we === 1'b1) begin
            wa.push_back(addr);
            wd.push_back(wdata);
            wt.push_back(cyc);
        end
    end
    cdp_loader #(
        .FAST_CYC (FAST),
        .STD_CYC  (STD)
    ) u_cdp_loader (
        .CLK_I                    (clk),
        .RESETN_I                 (resetn),
        .CE_I                     (ce),
        .CORE_SUPPLY_GOOD_I       (core_ok),
        .ANALOG_SUPPLY_GOOD_I     (ana_ok),
        .IO_SUPPLY_GOOD_I         (io_ok),
        .MODE_SELECT_PINS_I       (mode),
        .REMOTE_OPTION_I          (remote_opt),
        .TEST_PORT_CFG_I          (test_port),
        .RESTART_INPUT_N_I        (restart_n),
        .CFG_VALID_I              (cfg_valid),
        .CFG_DATA_I               (cfg_data),
        .STATUS_OPEN_DRAIN_N_O    (st_od),
        .STATUS_OPEN_DRAIN_N_OE_O (st_oe),
        .LOAD_COMPLETE_O          (done_od),
        .LOAD_COMPLETE_OE_O       (done_oe),
        .DEVICE_IN_RESET_O        (in_rst),
        .REMOTE_UPDATE_O          (remote),
        .CELL_WE_O                (we),
        .CELL_ADDR_O              (addr),
        .CELL_DATA_O              (wdata)
    );
    cdp_cfg_src u_cdp_cfg_src (
        .clk_i       (clk),
        .restart_n_o (restart_n),
        .valid_o     (cfg_valid),
        .data_o      (cfg_data)
    );
    // ==========================================================
    // helpers
    task automatic do_reset(input logic [2:0] m);
        @(posedge clk);
        resetn <= 1'b0;
        mode   <= m;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
    endtask
    // bounded wait for the status pin to be released
    task automatic wait_up(output int n);
        n = 0;
        while (st_oe !== 1'b0 && n < 200) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask
    task automatic ready();
        int n;
        u_cdp_cfg_src.set_restart(1'b0);
        repeat (2) @(posedge clk);
        u_cdp_cfg_src.set_restart(1'b1);
        wait_up(n);
        wa.delete();
        wd.delete();
        wt.delete();
    endtask
    // ==========================================================
    // scenarios
    task automatic t_por(input logic fast);
        int n;
        int lim;
        lim = fast ? FAST : STD;
        u_cdp_cfg_src.set_restart(1'b1);
        do_reset({fast, 2'h0});
        @(posedge clk);
        #1;
        `CHK("por_status_oe", 1'b1, st_oe)
        `CHK("por_in_reset", 1'b1, in_rst)
        `CHK("status_level", 1'b0, st_od)
        wait_up(n);
        `CHK("por_delay", 1'b1, n >= lim - 1 && n <= lim + 4)
        `CHK("out_of_reset", 1'b0, in_rst)
    endtask
    task automatic t_io_supply();
        int n;
        @(posedge clk);
        io_ok <= 1'b0;
        do_reset(3'h4);
        repeat (STD + 5) @(posedge clk);
        #1;
        `CHK("io_low_status_oe", 1'b1, st_oe)
        @(posedge clk);
        io_ok <= 1'b1;
        wait_up(n);
        `CHK("io_good_delay", 1'b1, n >= FAST - 1 && n <= FAST + 4)
    endtask
    task automatic t_brown();
        int n;
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            core_ok <= (i == 1);
            ana_ok  <= (i == 0);
            @(posedge clk);
            core_ok <= 1'b1;
            ana_ok  <= 1'b1;
            @(posedge clk);
            #1;
            `CHK("brown_in_reset", 1'b1, in_rst)
            `CHK("brown_status_oe", 1'b1, st_oe)
            wait_up(n);
            `CHK("brown_restart", 1'b1, n >= FAST - 3 && n <= FAST + 4)
        end
    endtask
    task automatic t_restart();
        int n;
        u_cdp_cfg_src.set_restart(1'b0);
        repeat (3) @(posedge clk);
        #1;
        `CHK("restart_in_reset", 1'b1, in_rst)
        `CHK("restart_status_oe", 1'b1, st_oe)
        `CHK("restart_done_oe", 1'b1, done_oe)
        u_cdp_cfg_src.set_restart(1'b1);
        wait_up(n);
        `CHK("restart_release", 1'b1, n <= 3)
    endtask
    task automatic t_raw();
        @(posedge clk);
        mode <= 3'h7;
        ready();
        u_cdp_cfg_src.send(8'h00);
        u_cdp_cfg_src.send(8'h00);
        u_cdp_cfg_src.send(8'h02);
        u_cdp_cfg_src.send(8'ha5);
        `CHK("raw_done_early", 1'b1, done_oe)
        u_cdp_cfg_src.send(8'h00);
        `CHK("raw_count", 2, wa.size())
        `CHK("raw_addr0", 16'h0000, wa[0])
        `CHK("raw_data0", 8'ha5, wd[0])
        `CHK("raw_addr1", 16'h0001, wa[1])
        `CHK("raw_data1", 8'h00, wd[1])
        `CHK("raw_done", 1'b0, done_oe)
        `CHK("done_level", 1'b0, done_od)
        u_cdp_cfg_src.send(8'h77);
        `CHK("raw_extra_ignored", 2, wa.size())
    endtask
    task automatic t_comp();
        logic [7:0] exp [5];
        exp = '{8'h7e, 8'h00, 8'h00, 8'h00, 8'h11};
        @(posedge clk);
        mode <= 3'h4;
        ready();
        u_cdp_cfg_src.send(8'h01);
        u_cdp_cfg_src.send(8'h00);
        u_cdp_cfg_src.send(8'h05);
        u_cdp_cfg_src.send(8'h7e);
        u_cdp_cfg_src.send(8'h00);
        u_cdp_cfg_src.send(8'h02);
        `CHK("comp_run_done_early", 1'b1, done_oe)
        u_cdp_cfg_src.send(8'h11);
        `CHK("comp_count", 5, wa.size())
        for (int i = 0; i < 5; i++) begin
            `CHK("comp_addr", i[15:0], wa[i])
            `CHK("comp_data", exp[i], wd[i])
        end
        `CHK("comp_run_gap1", 1, wt[2] - wt[1])
        `CHK("comp_run_gap2", 1, wt[3] - wt[2])
        `CHK("comp_done", 1'b0, done_oe)
    endtask
    task automatic t_err();
        @(posedge clk);
        mode <= 3'h7;
        ready();
        u_cdp_cfg_src.send(8'h01);
        u_cdp_cfg_src.send(8'h00);
        u_cdp_cfg_src.send(8'h01);
        u_cdp_cfg_src.send(8'h33);
        `CHK("err_status_oe", 1'b1, st_oe)
        `CHK("err_no_write", 0, wa.size())
        ready();
        `CHK("err_recovered", 1'b0, st_oe)
    endtask
    // enable low must freeze the sequencer even against a restart
    task automatic t_ce();
        int n;
        @(posedge clk);
        ce <= 1'b0;
        u_cdp_cfg_src.set_restart(1'b0);
        repeat (3) @(posedge clk);
        #1;
        `CHK("ce_frozen", 1'b0, in_rst)
        `CHK("ce_frozen_oe", 1'b0, st_oe)
        @(posedge clk);
        ce <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        `CHK("ce_resumed", 1'b1, in_rst)
        u_cdp_cfg_src.set_restart(1'b1);
        wait_up(n);
        `CHK("ce_release", 1'b1, n <= 3)
    endtask
    task automatic t_remote();
        logic e;
        for (int k = 0; k < 16; k++) begin
            @(posedge clk);
            mode       <= {1'b1, k[1:0]};
            remote_opt <= k[2];
            test_port  <= k[3];
            repeat (2) @(posedge clk);
            #1;
            e = k[2] && (k[1:0] < 2) && !k[3];
            `CHK("remote_update", e, remote)
        end
    endtask
    // ==========================================================
    // verdict
    task automatic finish_test();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // run is a few hundred cycles; the limit leaves ample room
    initial begin
        repeat (8000) @(posedge clk);
        fails++;
        finish_test();
    end
    initial begin
        resetn     = 1'b0;
        ce         = 1'b1;
        core_ok    = 1'b1;
        ana_ok     = 1'b1;
        io_ok      = 1'b1;
        mode       = 3'h4;
        remote_opt = 1'b0;
        test_port  = 1'b0;
        t_por(1'b1);
        t_por(1'b0);
        t_io_supply();
        t_brown();
        t_restart();
        t_raw();
        t_comp();
        t_err();
        t_ce();
        t_remote();
        finish_test();
    end
endmodule
